// ### rtl/meas_cmd_decoder.sv
// measurement command decoder: link-side request capture and core sequencer
`timescale 1ns/1ns
module meas_cmd_decoder (
  input wire logic i_mclk,
  input wire logic i_srst,
  // link side, on the serial layer clock
  input wire logic i_lclk,
  input wire logic i_spi_mode,
  input wire logic i_req_valid,
  input wire logic [meas_cmd_pkg::CMD_W-1:0] i_req_cmd,
  input wire logic [meas_cmd_pkg::SETUP_W-1:0] i_req_arg,
  output logic o_req_ready,
  output logic o_resp_valid,
  output logic [7:0] o_status,
  output logic [meas_cmd_pkg::DATA_W-1:0] o_resp_sensor,
  output logic [meas_cmd_pkg::DATA_W-1:0] o_resp_temp,
  // core side, on i_mclk
  input wire logic i_mem_error,
  input wire logic [meas_cmd_pkg::SETUP_W-1:0] i_stored_setup,
  input wire logic [meas_cmd_pkg::SETUP_W-1:0] i_factory_temp_setup,
  output logic [meas_cmd_pkg::ADDR_W-1:0] o_setup_addr,
  output logic o_phase_start,
  output logic [1:0] o_phase,
  output logic [meas_cmd_pkg::SETUP_W-1:0] o_phase_setup,
  input wire logic i_phase_done,
  input wire logic [meas_cmd_pkg::DATA_W-1:0] i_phase_sample,
  output logic o_calc_start,
  input wire logic i_calc_done,
  input wire logic [meas_cmd_pkg::DATA_W-1:0] i_calc_sensor,
  input wire logic [meas_cmd_pkg::DATA_W-1:0] i_calc_temp,
  input wire logic i_calc_sat,
  output logic o_power_down,
  output logic o_sleep
);
  import meas_cmd_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_PHASE_REQ, S_PHASE_WAIT, S_CALC_WAIT, S_FINISH
  } core_state_t;

  // ---------------- link domain ----------------
  logic [1:0] lrst_q;
  logic lrst;
  logic req_tog_q;
  logic ack_tog_l;
  logic ack_seen_q;
  logic pending;
  logic [CMD_W-1:0] cmd_q;
  logic [SETUP_W-1:0] arg_q;
  logic mem_err_l;
  logic sel_l_q;
  logic sat_l_q;
  logic is_nop;
  // core-side state read by the link copy, declared ahead of its first use
  logic ack_tog_c_q;
  logic sel_q;
  logic sat_q;
  logic [DATA_W-1:0] res_sensor_q;
  logic [DATA_W-1:0] res_temp_q;

  function automatic logic nop_code(input logic [CMD_W-1:0] c);
    return c[7:4] == CMD_NOP_NIBBLE;
  endfunction

  // reset carried into the link clock
  always_ff @(posedge i_lclk) begin
    lrst_q <= {lrst_q[0], i_srst};
  end
  assign lrst = lrst_q[1];

  level_sync #(.W(1)) u_ack_sync (.i_clk(i_lclk), .i_d(ack_tog_c_q), .o_q(ack_tog_l));
  level_sync #(.W(1)) u_err_sync (.i_clk(i_lclk), .i_d(i_mem_error), .o_q(mem_err_l));

  assign pending = req_tog_q != ack_tog_l;
  assign is_nop = nop_code(i_req_cmd);
  assign o_req_ready = !pending && !lrst && !o_status[ST_BUSY]; // ready never beside busy

  // accept one request while idle; busy blocks new ones
  always_ff @(posedge i_lclk) begin
    if (lrst) begin
      req_tog_q <= 1'b0;
      cmd_q <= '0;
      arg_q <= '0;
    end else if (i_req_valid && o_req_ready && !is_nop) begin
      req_tog_q <= !req_tog_q;
      cmd_q <= i_req_cmd;
      arg_q <= i_req_arg;
    end
  end

  // copy core results once the acknowledge returns
  always_ff @(posedge i_lclk) begin
    if (lrst) begin
      ack_seen_q <= 1'b0;
      sel_l_q <= 1'b0;
      sat_l_q <= 1'b0;
      o_resp_sensor <= '0;
      o_resp_temp <= '0;
    end else if (ack_tog_l != ack_seen_q) begin
      ack_seen_q <= ack_tog_l;
      sel_l_q <= sel_q;
      sat_l_q <= sat_q;
      o_resp_sensor <= res_sensor_q;
      o_resp_temp <= res_temp_q;
    end
  end

  // status byte, refreshed every link cycle
  always_ff @(posedge i_lclk) begin
    if (lrst) begin
      o_status <= '0;
    end else begin
      o_status <= '0;
      o_status[ST_POWERED] <= 1'b1;
      o_status[ST_BUSY] <= pending;
      o_status[ST_MEM_ERR] <= mem_err_l;
      o_status[ST_SETUP_SEL] <= sel_l_q;
      o_status[ST_SATURATION] <= sat_l_q;
    end
  end

  // no-op poll answers only in spi mode
  always_ff @(posedge i_lclk) begin
    if (lrst) begin
      o_resp_valid <= 1'b0;
    end else begin
      o_resp_valid <= i_req_valid && is_nop && i_spi_mode;
    end
  end

  // ---------------- core domain ----------------
  core_state_t state_q;
  logic req_tog_c;
  logic req_seen_q;
  logic [SETUP_W-1:0] carg_q;
  logic full_q;
  logic supplied_q;
  logic autozero_q;
  phase_t phase_q;
  phase_t first_q;
  phase_t last_q;
  logic [2:0] log2n_q;
  logic [MAX_LOG2_SAMPLES:0] count_q;
  logic [DATA_W-1:0] az_q;
  logic new_req;
  logic acc_clear;
  logic acc_add;
  logic [DATA_W-1:0] mean_sensor;
  logic [DATA_W-1:0] mean_temp;
  logic [MAX_LOG2_SAMPLES:0] n_last;
  logic temp_ph;

  level_sync #(.W(1)) u_req_sync (.i_clk(i_mclk), .i_d(req_tog_q), .o_q(req_tog_c));

  assign new_req = (req_tog_c != req_seen_q) && (state_q == S_IDLE);
  assign acc_clear = new_req;
  assign acc_add = (state_q == S_CALC_WAIT) && i_calc_done;
  assign n_last = (MAX_LOG2_SAMPLES + 1)'((1 << log2n_q) - 1);
  assign temp_ph = (phase_q == autozero_temperature_phase) || (phase_q == temperature_phase);

  mean_accum #(.DW(DATA_W), .LOGMAX(MAX_LOG2_SAMPLES)) u_mean (
    .i_mclk(i_mclk),
    .i_clear(acc_clear),
    .i_add(acc_add),
    .i_sensor(i_calc_sensor),
    .i_temp(i_calc_temp),
    .i_log2n(log2n_q),
    .o_sensor_mean(mean_sensor),
    .o_temp_mean(mean_temp)
  );

  // front-end setup feeding each phase
  always_comb begin
    o_setup_addr = sel_q ? ALTERNATE_SETUP_ADDR : PRIMARY_SETUP_ADDR;
    o_phase = phase_q;
    if (temp_ph) begin
      o_phase_setup = supplied_q ? (carg_q & TEMP_SETUP_KEEP)
                                 : i_factory_temp_setup;
    end else begin
      o_phase_setup = supplied_q ? carg_q : i_stored_setup;
    end
  end

  // request latch and command decode
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      req_seen_q <= 1'b0;
      carg_q <= '0;
      full_q <= 1'b0;
      supplied_q <= 1'b0;
      autozero_q <= 1'b0;
      first_q <= sensor_phase;
      last_q <= sensor_phase;
      log2n_q <= '0;
    end else if (new_req) begin
      req_seen_q <= req_tog_c;
      carg_q <= arg_q;
      full_q <= cmd_q[7:2] == CMD_OVS_PREFIX;
      log2n_q <= 3'(cmd_q[1:0] - CMD_OVS_FIRST[1:0]) + 3'h1;
      if (cmd_q[7:2] == CMD_OVS_PREFIX) begin
        supplied_q <= 1'b0;
        autozero_q <= 1'b0;
        first_q <= autozero_sensor_phase;
        last_q <= temperature_phase;
      end else begin
        supplied_q <= cmd_q[RAW_BIT_SUPPLIED];
        autozero_q <= cmd_q[RAW_BIT_AUTOZERO];
        if (cmd_q[RAW_BIT_TEMP]) begin
          first_q <= cmd_q[RAW_BIT_AUTOZERO] ? autozero_temperature_phase
                                             : temperature_phase;
          last_q <= temperature_phase;
        end else begin
          first_q <= cmd_q[RAW_BIT_AUTOZERO] ? autozero_sensor_phase : sensor_phase;
          last_q <= sensor_phase;
        end
      end
    end
  end

  // sequencer through phases, correction and averaging
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_q <= S_IDLE;
      phase_q <= sensor_phase;
      count_q <= '0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (new_req) begin
            count_q <= '0;
            if (cmd_q[7:2] == CMD_OVS_PREFIX) begin
              phase_q <= autozero_sensor_phase;
              state_q <= S_PHASE_REQ;
            end else if (cmd_q[7:3] == CMD_RAW_PREFIX) begin
              phase_q <= cmd_q[RAW_BIT_TEMP]
                ? (cmd_q[RAW_BIT_AUTOZERO] ? autozero_temperature_phase : temperature_phase)
                : (cmd_q[RAW_BIT_AUTOZERO] ? autozero_sensor_phase : sensor_phase);
              state_q <= S_PHASE_REQ;
            end else begin
              state_q <= S_FINISH;
            end
          end
        end
        S_PHASE_REQ: state_q <= S_PHASE_WAIT;
        S_PHASE_WAIT: begin
          if (i_phase_done) begin
            if (phase_q != last_q) begin
              phase_q <= phase_t'(phase_q + 2'h1);
              state_q <= S_PHASE_REQ;
            end else if (full_q) begin
              state_q <= S_CALC_WAIT;
            end else begin
              state_q <= S_FINISH;
            end
          end
        end
        S_CALC_WAIT: begin
          if (i_calc_done) begin
            if (count_q == n_last) begin
              state_q <= S_FINISH;
            end else begin
              count_q <= count_q + 1'b1;
              phase_q <= first_q;
              state_q <= S_PHASE_REQ;
            end
          end
        end
        S_FINISH: state_q <= S_IDLE;
      endcase
    end
  end

  // engine strobes
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_phase_start <= 1'b0;
      o_calc_start <= 1'b0;
    end else begin
      o_phase_start <= state_q == S_PHASE_REQ;
      o_calc_start <= (state_q == S_PHASE_WAIT) && i_phase_done && full_q
                      && (phase_q == last_q);
    end
  end

  // keep the auto-zero sample of a corrected raw run
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      az_q <= '0;
    end else if (state_q == S_PHASE_WAIT && i_phase_done && phase_q != last_q) begin
      az_q <= i_phase_sample;
    end
  end

  // results, saturation and setup selection
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      res_sensor_q <= '0;
      res_temp_q <= '0;
      sat_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      if (new_req) begin
        sat_q <= 1'b0;
        if (cmd_q == CMD_SEL_PRIMARY) sel_q <= 1'b0;
        if (cmd_q == CMD_SEL_ALTERNATE) sel_q <= 1'b1;
      end
      if (acc_add && i_calc_sat) sat_q <= 1'b1;
      if (state_q == S_PHASE_WAIT && i_phase_done && !full_q && phase_q == last_q) begin
        res_sensor_q <= autozero_q ? i_phase_sample - az_q : i_phase_sample;
        res_temp_q <= '0;
      end
      if (state_q == S_FINISH && full_q) begin
        res_sensor_q <= mean_sensor;
        res_temp_q <= mean_temp;
      end
    end
  end

  // power state and completion handshake
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_sleep <= 1'b0;
      o_power_down <= 1'b0;
      ack_tog_c_q <= 1'b0;
    end else begin
      o_power_down <= new_req && cmd_q == CMD_HALT_CYCLIC;
      if (new_req && cmd_q == CMD_HALT_CYCLIC) begin
        o_sleep <= 1'b1;
      end else if (new_req && (cmd_q[7:3] == CMD_RAW_PREFIX
                               || cmd_q[7:2] == CMD_OVS_PREFIX)) begin
        o_sleep <= 1'b0;
      end
      if (state_q == S_FINISH) ack_tog_c_q <= !ack_tog_c_q;
    end
  end
endmodule

// ### rtl/meas_cmd_pkg.sv
// constants and types for the measurement command decoder
// Notes on behaviour
// - command ac runs two full corrected measurements back to back and stores their mean.
// - command ad runs four full corrected measurements without pause and stores their mean.
// - command ae runs eight full corrected measurements without pause and stores their mean.
// - command af runs sixteen full corrected measurements without pause and stores their mean.
// - averaged result is a 24-bit corrected sensor word plus 24-bit temperature word.
// - b0 selects primary setup at location 12, clears status bit 1; reset default.
// - b1 selects alternate setup at location 16 and sets status bit 1.
// - bf powers the engine down and puts the device to sleep.
// - upper nibble f is a spi-only no-op returning status and last data.
// - a0 with zero word measures sensor raw using the selected stored setup.
// - a1 measures sensor raw using the host-supplied setup word.
// - a2/a3 give auto-zero corrected raw sensor data, stored or supplied setup.
// - a4/a5 give raw temperature, fixed factory setup or supplied setup.
// - a6/a7 give auto-zero corrected raw temperature data.
// - supplied setup bits 15:13 are ignored for temperature measurements.
// - each raw command makes one measurement, stores a 24-bit word; bit 0 picks setup.
// - full measurement runs auto-zero sensor, sensor, auto-zero temp, temp, then correction.
// - status bit 5 is high while a command runs; no new command is taken then.
package meas_cmd_pkg;
  localparam int DATA_W = 24;
  localparam int SETUP_W = 16;
  localparam int CMD_W = 8;
  localparam int MAX_LOG2_SAMPLES = 4;
  localparam int ADDR_W = 8;

  localparam logic [7:0] CMD_OVS_FIRST = 8'hac;
  localparam logic [7:0] CMD_SEL_PRIMARY = 8'hb0;
  localparam logic [7:0] CMD_SEL_ALTERNATE = 8'hb1;
  localparam logic [7:0] CMD_HALT_CYCLIC = 8'hbf;
  localparam logic [4:0] CMD_RAW_PREFIX = 5'h14;
  localparam logic [5:0] CMD_OVS_PREFIX = 6'h2b;
  localparam logic [3:0] CMD_NOP_NIBBLE = 4'hf;

  localparam int RAW_BIT_SUPPLIED = 0;
  localparam int RAW_BIT_AUTOZERO = 1;
  localparam int RAW_BIT_TEMP = 2;

  localparam logic [ADDR_W-1:0] PRIMARY_SETUP_ADDR = 8'h12;
  localparam logic [ADDR_W-1:0] ALTERNATE_SETUP_ADDR = 8'h16;
  localparam logic [SETUP_W-1:0] TEMP_SETUP_KEEP = 16'h1fff;

  localparam int ST_POWERED = 6;
  localparam int ST_BUSY = 5;
  localparam int ST_MEM_ERR = 2;
  localparam int ST_SETUP_SEL = 1;
  localparam int ST_SATURATION = 0;

  typedef enum logic [1:0] {
    autozero_sensor_phase,
    sensor_phase,
    autozero_temperature_phase,
    temperature_phase
  } phase_t;
endpackage

// ### rtl/level_sync.sv
// two-flop synchroniser for levels and toggles
`timescale 1ns/1ns
module level_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge i_clk) begin
    meta_q <= i_d;
    o_q <= meta_q;
  end
endmodule

// ### rtl/mean_accum.sv
// separate sensor and temperature accumulators with shift divide
`timescale 1ns/1ns
module mean_accum #(
  parameter int DW = 24,
  parameter int LOGMAX = 4
) (
  input wire logic i_mclk,
  input wire logic i_clear,
  input wire logic i_add,
  input wire logic [DW-1:0] i_sensor,
  input wire logic [DW-1:0] i_temp,
  input wire logic [2:0] i_log2n,
  output logic [DW-1:0] o_sensor_mean,
  output logic [DW-1:0] o_temp_mean
);
  localparam int AW = DW + LOGMAX;
  logic [AW-1:0] sens_acc_q;
  logic [AW-1:0] temp_acc_q;
  logic [AW-1:0] sens_sh;
  logic [AW-1:0] temp_sh;

  initial begin
    if (DW < 1 || LOGMAX < 1 || LOGMAX > 7) $error("mean_accum: bad parameters");
  end

  // widened sums so sixteen full-scale words never overflow
  always_ff @(posedge i_mclk) begin
    if (i_clear) begin
      sens_acc_q <= '0;
      temp_acc_q <= '0;
    end else if (i_add) begin
      sens_acc_q <= sens_acc_q + AW'(i_sensor);
      temp_acc_q <= temp_acc_q + AW'(i_temp);
    end
  end

  // divide by the power-of-two sample count
  always_comb begin
    sens_sh = sens_acc_q >> i_log2n;
    temp_sh = temp_acc_q >> i_log2n;
    o_sensor_mean = sens_sh[DW-1:0];
    o_temp_mean = temp_sh[DW-1:0];
  end
endmodule

// ### bench/meas_cmd_assertions.sv
// concurrent checks on the decoder's ports
`timescale 1ns/1ns
module meas_cmd_checker (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_lclk,
  input wire logic i_spi_mode,
  input wire logic i_req_valid,
  input wire logic [meas_cmd_pkg::CMD_W-1:0] i_req_cmd,
  input wire logic o_req_ready,
  input wire logic o_resp_valid,
  input wire logic [7:0] o_status,
  input wire logic [meas_cmd_pkg::ADDR_W-1:0] o_setup_addr,
  input wire logic o_phase_start,
  input wire logic [1:0] o_phase,
  input wire logic [meas_cmd_pkg::SETUP_W-1:0] o_phase_setup,
  input wire logic i_phase_done,
  input wire logic o_calc_start,
  input wire logic i_calc_done,
  input wire logic o_power_down,
  input wire logic o_sleep
);
  import meas_cmd_pkg::*;
  logic wait_q;
  logic calc_q;
  logic meas_cmd;
  logic sel_exp_q;
  // outstanding phase and calculation trackers
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wait_q <= 1'b0;
      calc_q <= 1'b0;
    end else begin
      wait_q <= o_phase_start | (wait_q & ~i_phase_done);
      calc_q <= o_calc_start | (calc_q & ~i_calc_done);
    end
  end
  // setup selection as last taken by the link
  always_ff @(posedge i_lclk) begin
    if (i_srst) begin
      sel_exp_q <= 1'b0;
    end else if (i_req_valid && o_req_ready && i_req_cmd == CMD_SEL_PRIMARY) begin
      sel_exp_q <= 1'b0;
    end else if (i_req_valid && o_req_ready && i_req_cmd == CMD_SEL_ALTERNATE) begin
      sel_exp_q <= 1'b1;
    end
  end
  // raw and averaged measurement command bytes
  assign meas_cmd = i_req_cmd[7:4] == 4'ha && (!i_req_cmd[3] || i_req_cmd[3:2] == 2'b11);
  sequence s_az_done;
    wait_q && i_phase_done && !o_phase[0];
  endsequence
  sequence s_next_start;
    ##2 o_phase_start && (o_phase == $past(o_phase, 2) + 2'd1);
  endsequence
  AST_NEXT_PHASE: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_az_done |-> s_next_start) else $error("phase after auto-zero not started in time");
  AST_CALC_AFTER_TEMP: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_calc_start |-> $past(i_phase_done) && $past(o_phase) == temperature_phase)
    else $error("calculation not right after temperature phase");
  AST_NO_PHASE_IN_CALC: assert property (@(posedge i_mclk) disable iff (i_srst)
    calc_q |-> !o_phase_start) else $error("phase started during calculation");
  AST_PHASE_STABLE: assert property (@(posedge i_mclk) disable iff (i_srst)
    wait_q && !o_phase_start |-> $stable(o_phase_setup) && $stable(o_phase))
    else $error("phase setup moved during phase");
  AST_SETUP_ADDR: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_phase_start |-> o_setup_addr == (sel_exp_q ? ALTERNATE_SETUP_ADDR : PRIMARY_SETUP_ADDR))
    else $error("setup address does not follow last selection");
  AST_POWER_DOWN: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_power_down |=> o_sleep && !o_power_down) else $error("power down without sleep");
  AST_SLEEP_CLEAR: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_phase_start |-> ##[0:1] !o_sleep) else $error("measuring while asleep");
  AST_BUSY_NOT_READY: assert property (@(posedge i_lclk) disable iff (i_srst)
    o_status[ST_BUSY] |-> !o_req_ready) else $error("ready while busy");
  AST_BUSY_AFTER_TAKE: assert property (@(posedge i_lclk) disable iff (i_srst)
    i_req_valid && o_req_ready && meas_cmd |-> ##2 o_status[ST_BUSY])
    else $error("busy not raised for measurement");
  AST_NOP_ANSWER: assert property (@(posedge i_lclk) disable iff (i_srst)
    o_status[ST_POWERED] && i_req_valid && i_req_cmd[7:4] == CMD_NOP_NIBBLE |=>
    o_resp_valid == $past(i_spi_mode)) else $error("no-op answer wrong for mode");
endmodule
bind meas_cmd_decoder meas_cmd_checker u_chk (.*);

// ### bench/engine_model.sv
// behavioural measurement engine and setup memory
`timescale 1ns/1ns
module engine_model (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_phase_start,
  input wire logic [1:0] i_phase,
  input wire logic [meas_cmd_pkg::SETUP_W-1:0] i_phase_setup,
  input wire logic i_calc_start,
  input wire logic [meas_cmd_pkg::ADDR_W-1:0] i_setup_addr,
  input wire logic [meas_cmd_pkg::SETUP_W-1:0] i_prim_word,
  input wire logic [meas_cmd_pkg::SETUP_W-1:0] i_alt_word,
  output logic [meas_cmd_pkg::SETUP_W-1:0] o_stored,
  output logic o_phase_done,
  output logic [meas_cmd_pkg::DATA_W-1:0] o_sample,
  output logic o_calc_done,
  output logic [meas_cmd_pkg::DATA_W-1:0] o_calc_sensor,
  output logic [meas_cmd_pkg::DATA_W-1:0] o_calc_temp
);
  import meas_cmd_pkg::*;
  logic busy_q;
  logic is_calc_q;
  logic k_q;
  logic [2:0] dly_q;
  logic [3:0] slow_q;
  logic [DATA_W-1:0] val_q;
  // answers after 1 to 4 cycles; data lines toggle when not valid
  always_ff @(posedge i_mclk) begin
    o_phase_done <= 1'b0;
    o_calc_done <= 1'b0;
    o_sample <= ~o_sample;
    o_calc_sensor <= ~o_calc_sensor;
    o_calc_temp <= ~o_calc_temp;
    if (i_srst) begin
      busy_q <= 1'b0;
      k_q <= 1'b0;
      slow_q <= 4'h0;
      o_sample <= '0;
      o_calc_sensor <= '0;
      o_calc_temp <= '0;
    end else if (i_phase_start || i_calc_start) begin
      busy_q <= 1'b1;
      is_calc_q <= i_calc_start;
      dly_q <= {1'b0, slow_q[1:0]} + 3'd1;
      slow_q <= slow_q + 4'h1;
      val_q <= {4'h0, i_phase, 2'b00, i_phase_setup};
    end else if (busy_q) begin
      dly_q <= dly_q - 3'd1;
      if (dly_q == 3'd1) begin
        busy_q <= 1'b0;
        if (is_calc_q) begin
          o_calc_done <= 1'b1;
          o_calc_sensor <= 24'h100000 + 24'({k_q, 1'b0});
          o_calc_temp <= 24'h020000 + 24'({k_q, 1'b0});
          k_q <= ~k_q;
        end else begin
          o_phase_done <= 1'b1;
          o_sample <= val_q;
        end
      end
    end
  end
  // setup memory read
  assign o_stored = (i_setup_addr == ALTERNATE_SETUP_ADDR) ? i_alt_word : i_prim_word;
endmodule

// ### bench/testbench.sv
// self-checking bench for the measurement command decoder
`timescale 1ns/1ns
module testbench;
  import meas_cmd_pkg::*;
  typedef struct packed {
    logic [7:0] st;
    logic [DATA_W-1:0] s;
    logic [DATA_W-1:0] t;
  } exp_t;
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic srst = 1'b1;
  logic spi_mode = 1'b1;
  logic req_valid = 1'b0;
  logic [CMD_W-1:0] req_cmd = 8'h00;
  logic [SETUP_W-1:0] req_arg = 16'h0000;
  logic req_ready, resp_valid, phase_start, calc_start, phase_done, calc_done, power_down, sleep;
  logic [7:0] status;
  logic [1:0] phase;
  logic [ADDR_W-1:0] setup_addr;
  logic [DATA_W-1:0] resp_s, resp_t, sample, calc_s, calc_t;
  logic [SETUP_W-1:0] stored, phase_setup, arg;
  logic [SETUP_W-1:0] prim = 16'h0000;
  logic [SETUP_W-1:0] alt = 16'h0000;
  logic [SETUP_W-1:0] factory = 16'h0000;
  logic [31:0] seed = 32'h0000bc6e;
  logic sel = 1'b0;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  exp_t got;
  exp_t exp_q[$];
  always #5 mclk = ~mclk;
  // link clock, 15 ns, offset from core clock
  always begin
    #3 lclk = 1'b1;
    #7 lclk = 1'b0;
    #5;
  end
  meas_cmd_decoder DUT (.i_mclk(mclk), .i_srst(srst), .i_lclk(lclk), .i_spi_mode(spi_mode),
    .i_req_valid(req_valid), .i_req_cmd(req_cmd), .i_req_arg(req_arg), .o_req_ready(req_ready),
    .o_resp_valid(resp_valid), .o_status(status), .o_resp_sensor(resp_s), .o_resp_temp(resp_t),
    .i_mem_error(1'b0), .i_stored_setup(stored), .i_factory_temp_setup(factory),
    .o_setup_addr(setup_addr), .o_phase_start(phase_start), .o_phase(phase),
    .o_phase_setup(phase_setup), .i_phase_done(phase_done), .i_phase_sample(sample),
    .o_calc_start(calc_start), .i_calc_done(calc_done), .i_calc_sensor(calc_s),
    .i_calc_temp(calc_t), .i_calc_sat(1'b0), .o_power_down(power_down), .o_sleep(sleep));
  engine_model u_eng (.i_mclk(mclk), .i_srst(srst), .i_phase_start(phase_start),
    .i_phase(phase), .i_phase_setup(phase_setup), .i_calc_start(calc_start),
    .i_setup_addr(setup_addr), .i_prim_word(prim), .i_alt_word(alt), .o_stored(stored),
    .o_phase_done(phase_done), .o_sample(sample), .o_calc_done(calc_done),
    .o_calc_sensor(calc_s), .o_calc_temp(calc_t));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction
  // expected raw word: phase code, setup used, auto-zero difference
  function automatic logic [DATA_W-1:0] raw_exp(input logic [2:0] i, input logic [15:0] a);
    logic [15:0] w;
    w = i[0] ? a : (i[2] ? factory : (sel ? alt : prim));
    if (i[2] && i[0]) w = a & 16'h1fff;
    if (i[1]) return 24'h040000;
    return {4'h0, i[2] ? 2'd3 : 2'd1, 2'b00, w};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    $display("MISMATCH t=%0t %s", $time, m);
    bad_count++;
  endtask
  // one whole request held for one link cycle
  task automatic poke(input logic [7:0] c, input logic [15:0] a);
    @(posedge lclk);
    #1 req_valid = 1'b1;
    req_cmd = c;
    req_arg = a;
    @(posedge lclk);
    #1 req_valid = 1'b0;
  endtask
  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(posedge lclk);
    #1;
    while ((status[ST_BUSY] !== 1'b0 || req_ready !== 1'b1) && n < 3000) begin
      @(posedge lclk);
      #1 n++;
    end
    if (n >= 3000) fail("wait for idle ran out");
  endtask
  task automatic nop(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] t);
    seed = xs(seed);
    exp_q.push_back(exp_t'({1'b0, 1'b1, 3'b000, 1'b0, sel, 1'b0, s, t}));
    poke({CMD_NOP_NIBBLE, seed[3:0]}, 16'h0000);
    repeat (2) @(posedge lclk);
  endtask
  task automatic run(input logic [7:0] c, input logic [15:0] a, input logic [DATA_W-1:0] s,
      input logic [DATA_W-1:0] t);
    poke(c, a);
    settle();
    nop(s, t);
  endtask
  // compares each no-op reply with the oldest note
  always @(posedge lclk) begin
    if (resp_valid === 1'b1) begin
      n_checks++;
      if (exp_q.size() == 0) begin
        fail("reply without request");
      end else begin
        got = exp_q.pop_front();
        if ({status, resp_s, resp_t} !== got) fail("reply differs");
      end
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 50000) begin
      fail("run took too long");
      test_done();
    end
  end
  initial begin
    seed = xs(seed);
    prim = seed[15:0];
    alt = seed[31:16];
    seed = xs(seed);
    factory = seed[15:0];
    repeat (12) @(posedge mclk);
    #1 srst = 1'b0;
    settle();
    // all raw forms, zero word or supplied setup
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      arg = i[0] ? seed[15:0] : 16'h0000;
      run(8'ha0 + 8'(i), arg, raw_exp(3'(i), arg), '0);
    end
    // alternate then primary setup
    for (int j = 1; j >= 0; j--) begin
      poke(CMD_SEL_PRIMARY | 8'(j), 16'h0000);
      settle();
      sel = j[0];
      run(8'ha0, 16'h0000, raw_exp(3'd0, 16'h0000), '0);
    end
    for (int i = 0; i < 4; i++) begin
      run(CMD_OVS_FIRST + 8'(i), 16'h0000, 24'h100001, 24'h020001);
    end
    // a select sent while busy is dropped
    poke(8'hae, 16'h0000);
    repeat (3) @(posedge lclk);
    poke(CMD_SEL_ALTERNATE, 16'h0000);
    settle();
    nop(24'h100001, 24'h020001);
    poke(CMD_HALT_CYCLIC, 16'h0000);
    settle();
    n_checks++;
    if (sleep !== 1'b1) fail("not asleep after halt");
    run(8'ha0, 16'h0000, raw_exp(3'd0, 16'h0000), '0);
    n_checks++;
    if (sleep !== 1'b0) fail("still asleep after measurement");
    spi_mode = 1'b0;
    poke(8'hf3, 16'h0000);
    repeat (4) @(posedge lclk);
    n_checks++;
    if (exp_q.size() != 0) fail("replies missing");
    test_done();
  end
endmodule
